// >>> hw/lef_pkg.sv
// latched event flag package: register map, fields, resets, timing, carriers
package lef_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_FLAGS = 8'h00;
	localparam logic [7:0] ADDR_MASK = 8'h01;
	localparam logic [7:0] ADDR_LIVE = 8'h02;
	localparam logic [7:0] ADDR_INTEG = 8'h03;
	localparam logic [7:0] ADDR_SOFT_RST = 8'h04;
	localparam logic [7:0] ADDR_CURR = 8'h05;
	localparam logic [7:0] ADDR_FUNC = 8'h06;
	localparam logic [7:0] ADDR_DRV = 8'h07;
	localparam logic [7:0] ADDR_AUX = 8'h08;
	localparam logic [7:0] ADDR_CLKO = 8'h09;
	localparam logic [7:0] ADDR_TRIM = 8'h0a;
	localparam logic [7:0] ADDR_WAKE_REQ = 8'h0b;
	localparam logic [7:0] ADDR_PART_ID = 8'h0c;
	// flag, mask and other register bit positions
	localparam int BIT_NOT_READY = 7;
	localparam int BIT_WAKE = 6;
	localparam int BIT_DRV_FAULT = 4;
	localparam int BIT_SUP_WARN = 3;
	localparam int BIT_SUP_UV = 2;
	localparam int BIT_TH_SHUT = 1;
	localparam int BIT_TH_WARN = 0;
	localparam int BIT_SOFT_RST = 7;
	localparam int BIT_CORRUPT = 7;
	localparam int BIT_LINE_LVL = 7;
	localparam int BIT_AUX_LVL = 6;
	// reset values and writable bits of the mask
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] CURR_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] MASKABLE = 8'h5f;
	// writable register array and index of the mask in it
	localparam int NUM_WR = 8;
	localparam logic [2:0] IDX_MASK = 3'h0;
	// asynchronous source order in the synchroniser bank
	localparam int SRC_LINE = 6;
	localparam int SRC_AUX = 7;
	localparam int SRC_RAIL = 8;
	localparam int SRC_DIST = 9;
	localparam int NUM_SRC = 10;
	// wake pulse length
	localparam int WAKE_PULSE_US = 200;
	localparam int CLK_MHZ = 125;
	localparam int WAKE_PULSE_CYCLES = WAKE_PULSE_US * CLK_MHZ;
	// arbitrary part identifier value
	localparam logic [7:0] PART_ID_DEFAULT = 8'h5a;
	// raw comparator conditions, wake at the top
	typedef struct packed {
		logic wake;
		logic drv_fault;
		logic sup_warn;
		logic sup_uv;
		logic th_shut;
		logic th_warn;
	} lef_cond_t;
	// one register access from the serial port engine
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lef_req_t;
endpackage

// >>> hw/lef_sync.sv
// three-stage synchroniser with agreement filter and onset pulse
`timescale 1ns/1ps
module lef_sync (
	input wire logic mclk,
	input wire logic reset,
	input wire logic async_in,
	output logic level,
	output logic rise
);
	logic s1;
	logic s2;
	logic s3;

	// shift chain, first stage feeds only the second
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// accept a change once stages two and three agree
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			level <= 1'b0;
			rise <= 1'b0;
		end
		else
		begin
			if (s2 == s3)
				level <= s3;
			rise <= (s2 == s3) && s3 && !level;
		end
	end
endmodule

// >>> hw/lef_pulse_timer.sv
// retriggerable fixed-length pulse
`timescale 1ns/1ps
module lef_pulse_timer #(
	parameter int CYCLES = 25000
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic start,
	output logic active
);
	logic [15:0] cnt;

	// load on start, active for exactly CYCLES clocks
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			cnt <= 16'h0000;
			active <= 1'b0;
		end
		else if (start)
		begin
			cnt <= 16'(CYCLES);
			active <= 1'b1;
		end
		else if (cnt > 16'h0001)
			cnt <= cnt - 16'h0001;
		else
		begin
			cnt <= 16'h0000;
			active <= 1'b0;
		end
	end
endmodule

// >>> hw/lef_event_flags.sv
// latched event flags, mask, integrity check and register file
`timescale 1ns/1ps

// How it works
// - internal rail undervoltage resets every register and sets the not-ready flag (bit 7).
// - after power-up all registers take defaults and not-ready is then set until the flags are read.
// - a detected register upset or parity mismatch sets not-ready while the corruption indicator stands.
// - not-ready always pulls the interrupt output low and has no mask bit.
// - a wake-up onset sets the wake flag (bit 6), which holds until the next flag read.
// - a driver overcurrent, overload or driver thermal fault sets the driver-fault flag (bit 4).
// - the supply warning comparator sets the supply-warning flag (bit 3).
// - the supply undervoltage comparator sets the supply-undervoltage flag (bit 2).
// - entering thermal shutdown sets the thermal-shutdown flag (bit 1).
// - crossing the thermal warning threshold sets the thermal-warning flag (bit 0).
// - flags are sticky and one read of the flag register clears them all together.
// - an unmasked set flag holds the interrupt output low; a mask bit of one blocks it.
// - with the wake mask set, a wake-up gives a fixed 200 us low pulse instead.
module lef_event_flags #(
	parameter int WAKE_PULSE_CYCLES = lef_pkg::WAKE_PULSE_CYCLES,
	parameter logic [7:0] PART_ID = lef_pkg::PART_ID_DEFAULT
) (
	input wire logic mclk,
	input wire logic reset,
	input wire lef_pkg::lef_req_t bus_req,
	input wire lef_pkg::lef_cond_t cond_raw,
	input wire logic line_low_raw,
	input wire logic aux_low_raw,
	input wire logic rail_uv_raw,
	input wire logic disturb_raw,
	output logic [7:0] rd_data,
	output logic event_output_n,
	output logic driver_off,
	output logic [lef_pkg::NUM_WR-1:0][7:0] config_bytes
);
	// writable register index: {valid, index}
	function automatic logic [3:0] wr_index(input logic [7:0] a);
		logic [3:0] r;
		r = 4'h0;
		if (a == lef_pkg::ADDR_MASK)
			r = {1'b1, lef_pkg::IDX_MASK};
		else if (a >= lef_pkg::ADDR_CURR && a <= lef_pkg::ADDR_WAKE_REQ)
			r = {1'b1, 3'(a - lef_pkg::ADDR_SOFT_RST)};
		return r;
	endfunction

	// default value of a writable register
	function automatic logic [7:0] reg_default(input logic [2:0] idx);
		logic [7:0] r;
		r = lef_pkg::CFG_RESET;
		if (idx == lef_pkg::IDX_MASK)
			r = lef_pkg::MASK_RESET;
		else if (idx == 3'h1)
			r = lef_pkg::CURR_RESET;
		return r;
	endfunction

	// even parity of one byte
	function automatic logic parity(input logic [7:0] v);
		return ^v;
	endfunction

	logic [lef_pkg::NUM_SRC-1:0] raw;
	logic [lef_pkg::NUM_SRC-1:0] lvl;
	logic [lef_pkg::NUM_SRC-1:0] rise;
	logic [7:0] flags;
	logic [7:0] next_flags;
	logic [7:0] onset;
	logic [7:0] mask;
	logic [7:0] live;
	logic [7:0] next_rd_data;
	logic [7:0] wr_value;
	logic [3:0] wsel;
	logic [lef_pkg::NUM_WR-1:0] par;
	logic [lef_pkg::NUM_WR-1:0] mismatch;
	logic [lef_pkg::NUM_WR-1:0] rewritten;
	logic corrupt;
	logic por_pending;
	logic pulse_active;
	logic rail_lvl;
	logic soft_hit;
	logic wipe;
	logic wr_hit;
	logic rd_flags;
	logic nr_set;
	logic masked_any;

	// gather every asynchronous source into one bank
	assign raw = {disturb_raw, rail_uv_raw, aux_low_raw, line_low_raw, cond_raw};

	// one synchroniser per source
	generate
		for (genvar g = 0; g < lef_pkg::NUM_SRC; g++)
		begin : g_sync
			lef_sync u_sync (
				.mclk(mclk),
				.reset(reset),
				.async_in(raw[g]),
				.level(lvl[g]),
				.rise(rise[g])
			);
		end
	endgenerate

	// decode of the current access
	assign rail_lvl = lvl[lef_pkg::SRC_RAIL];
	assign wsel = wr_index(bus_req.addr);
	assign wr_hit = bus_req.wr && wsel[3];
	assign soft_hit = bus_req.wr && bus_req.addr == lef_pkg::ADDR_SOFT_RST && bus_req.wdata[lef_pkg::BIT_SOFT_RST];
	assign wipe = rail_lvl || soft_hit;
	assign rd_flags = bus_req.rd && bus_req.addr == lef_pkg::ADDR_FLAGS;
	assign mask = config_bytes[lef_pkg::IDX_MASK];

	// reserved mask bits never store, so they read back as zero
	assign wr_value = (wsel[2:0] == lef_pkg::IDX_MASK) ? (bus_req.wdata & lef_pkg::MASKABLE) : bus_req.wdata;

	// writable registers, back to defaults on rail loss or soft reset
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < lef_pkg::NUM_WR; i++)
			begin
				config_bytes[i] <= reg_default(3'(i));
				par[i] <= parity(reg_default(3'(i)));
			end
		end
		else if (wipe)
		begin
			for (int i = 0; i < lef_pkg::NUM_WR; i++)
			begin
				config_bytes[i] <= reg_default(3'(i));
				par[i] <= parity(reg_default(3'(i)));
			end
		end
		else if (wr_hit)
		begin
			config_bytes[wsel[2:0]] <= wr_value;
			par[wsel[2:0]] <= parity(wr_value);
		end
	end

	// continuous parity check of every stored byte
	generate
		for (genvar g = 0; g < lef_pkg::NUM_WR; g++)
		begin : g_check
			assign mismatch[g] = parity(config_bytes[g]) ^ par[g];
		end
	endgenerate

	// corruption indicator: set by upset, cleared once all bytes rewritten
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			corrupt <= 1'b0;
			rewritten <= '0;
		end
		else if (wipe)
		begin
			corrupt <= 1'b0;
			rewritten <= '0;
		end
		else if (rise[lef_pkg::SRC_DIST] || (|mismatch))
		begin
			corrupt <= 1'b1;
			rewritten <= '0;
		end
		else
		begin
			if (wr_hit)
				rewritten[wsel[2:0]] <= 1'b1;
			if (&rewritten)
				corrupt <= 1'b0;
		end
	end

	// power-up marker, gone one clock after release
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			por_pending <= 1'b1;
		else
			por_pending <= 1'b0;
	end

	// condition onsets placed at their flag bits
	assign onset = {1'b0, rise[5], 1'b0, rise[4:0]};
	assign nr_set = por_pending || rail_lvl || corrupt;

	// flag update: clear on read or wipe, then sets win
	always_comb
	begin
		next_flags = flags;
		if (rd_flags)
			next_flags = lef_pkg::FLAGS_RESET;
		if (wipe)
			next_flags = lef_pkg::FLAGS_RESET;
		next_flags = next_flags | onset;
		if (nr_set)
			next_flags[lef_pkg::BIT_NOT_READY] = 1'b1;
	end

	// sticky flag register
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			flags <= lef_pkg::FLAGS_RESET;
		else
			flags <= next_flags;
	end

	// live condition view
	assign live = {lvl[lef_pkg::SRC_LINE], lvl[lef_pkg::SRC_AUX], 1'b0, lvl[4:0]};

	// read multiplexer, unmapped and write-only read as zero
	always_comb
	begin
		next_rd_data = 8'h00;
		if (wsel[3])
			next_rd_data = config_bytes[wsel[2:0]];
		else
		begin
			unique case (bus_req.addr)
				lef_pkg::ADDR_FLAGS: next_rd_data = flags;
				lef_pkg::ADDR_LIVE: next_rd_data = live;
				lef_pkg::ADDR_INTEG: next_rd_data = {corrupt, 7'h00};
				lef_pkg::ADDR_PART_ID: next_rd_data = PART_ID;
				default: next_rd_data = 8'h00;
			endcase
		end
	end

	// read data latched on the same edge the flags clear
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			rd_data <= 8'h00;
		else if (bus_req.rd)
			rd_data <= next_rd_data;
	end

	// wake pulse instead of a latched assertion when masked
	lef_pulse_timer #(
		.CYCLES(WAKE_PULSE_CYCLES)
	) u_wake_pulse (
		.mclk(mclk),
		.reset(reset),
		.start(rise[5] && mask[lef_pkg::BIT_WAKE]),
		.active(pulse_active)
	);

	// any maskable flag set with its mask bit clear
	assign masked_any = |(flags & lef_pkg::MASKABLE & ~mask);

	// active-low interrupt output, not-ready unmaskable
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			event_output_n <= 1'b1;
		else
			event_output_n <= !(flags[lef_pkg::BIT_NOT_READY] || masked_any || pulse_active);
	end

	// line driver held off while not ready or corrupted
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			driver_off <= 1'b1;
		else
			driver_off <= flags[lef_pkg::BIT_NOT_READY] || nr_set;
	end

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	sequence s_flag_read;
		bus_req.rd && bus_req.addr == lef_pkg::ADDR_FLAGS;
	endsequence

	sequence s_quiet;
		!nr_set && !wipe && onset == 8'h00;
	endsequence

	sequence s_wake_masked;
		rise[5] && mask[lef_pkg::BIT_WAKE];
	endsequence

	sequence s_rewrite_done;
		corrupt && (&rewritten) && !wipe && !rise[lef_pkg::SRC_DIST] && mismatch == '0;
	endsequence

	sequence s_mask_write;
		wr_hit && wsel[2:0] == lef_pkg::IDX_MASK && !wipe;
	endsequence

	AST_POR_NOT_READY: assert property (por_pending |=> flags[lef_pkg::BIT_NOT_READY] && driver_off)
		else $error("not-ready missing after power-up");
	AST_RAIL_WIPE: assert property (rail_lvl |=> flags[7] && mask == lef_pkg::MASK_RESET && !corrupt)
		else $error("rail loss did not wipe registers");
	AST_CORRUPT_NR: assert property (corrupt |=> flags[7] ##1 driver_off)
		else $error("corruption did not raise not-ready");
	AST_NR_OUTPUT: assert property (flags[7] |=> !event_output_n)
		else $error("not-ready did not pull output low");
	AST_ONSET_SETS: assert property ((onset != 8'h00) |=> (flags & $past(onset)) == $past(onset))
		else $error("condition onset did not set its flag");
	AST_READ_CLEARS: assert property (s_flag_read ##0 s_quiet |=> flags == lef_pkg::FLAGS_RESET)
		else $error("flag read did not clear all flags");
	AST_READ_DATA: assert property (s_flag_read |=> rd_data == $past(flags))
		else $error("read data not the pre-clear flags");
	AST_READ_KEEPS_EVENT: assert property (s_flag_read ##0 (onset != 8'h00) |=> (flags & $past(onset)) != 8'h00)
		else $error("event lost during flag read");
	AST_MASKED_LOW: assert property (masked_any |=> !event_output_n)
		else $error("unmasked flag did not assert output");
	AST_MASK_BLOCKS: assert property (!masked_any && !flags[7] && !pulse_active |=> event_output_n)
		else $error("output asserted with all flags masked");
	AST_WAKE_PULSE: assert property (s_wake_masked |=> pulse_active [*8])
		else $error("wake pulse shorter than expected");
	AST_WAKE_OUT: assert property (s_wake_masked |=> ##1 !event_output_n [*7])
		else $error("wake pulse missing on output");
	AST_NO_RESET_HELD: assert property (lvl[0] && !rise[0] && !flags[0] |=> !flags[0])
		else $error("held condition set its flag again");

	// driver, power-up, recovery, wake and register checks
	AST_DRIVER_OFF_NR: assert property (nr_set |=> driver_off)
		else $error("driver not held off while not ready");
	AST_POR_OUTPUT: assert property (por_pending |=> ##1 !event_output_n)
		else $error("output not asserted after power-up");
	AST_CORRUPT_CLEARS: assert property (s_rewrite_done |=> !corrupt)
		else $error("corruption indicator stuck after rewrite");
	AST_WAKE_FLAG_MASKED: assert property (s_wake_masked |=> flags[lef_pkg::BIT_WAKE])
		else $error("masked wake did not set its flag");
	AST_WAKE_UNMASKED: assert property (rise[5] && !mask[lef_pkg::BIT_WAKE] && !wr_hit |=> ##1 !event_output_n)
		else $error("unmasked wake did not assert output");
	AST_MASK_WRITE: assert property (s_mask_write |=> mask == $past(wr_value))
		else $error("mask write did not land");
	AST_RD_HOLDS: assert property (!bus_req.rd |=> $stable(rd_data))
		else $error("read data changed without a read");
	AST_RESERVED_ZERO: assert property (!mask[7] && !mask[5] && !flags[5])
		else $error("reserved bit became set");
endmodule

// >>> verif/lef_host_model.sv
// host model: byte register accesses over the request bus
`timescale 1ns/1ps
module lef_host_model (
	input wire logic mclk,
	input wire logic [7:0] rd_data,
	output lef_pkg::lef_req_t bus_req
);
	// idle bus at time zero
	initial
	begin
		bus_req = '0;
	end

	// one write, strobe held for one edge, then address and data scrambled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		bus_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge mclk);
		bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// one read, data taken once the answer edge has passed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		bus_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge mclk);
		bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
		d = rd_data;
	endtask

	// recovery: rewrite every writable register before clearing not-ready
	task automatic rewrite(input logic [7:0] v[8]);
		wr(lef_pkg::ADDR_MASK, v[0] & lef_pkg::MASKABLE);
		for (int i = 1; i < 8; i++)
			wr(8'h04 + 8'(i), v[i]);
	endtask
endmodule

// >>> verif/latched_event_flag_register_test.sv
// self-checking bench for the latched event flag logic
`timescale 1ns/1ps
module latched_event_flag_register_test;
	localparam int PULSE = 16;
	logic mclk;
	logic reset;
	lef_pkg::lef_req_t bus_req;
	lef_pkg::lef_cond_t cond_raw;
	logic line_low_raw;
	logic aux_low_raw;
	logic rail_uv_raw;
	logic disturb_raw;
	logic [7:0] rd_data;
	logic event_output_n;
	logic driver_off;
	logic [lef_pkg::NUM_WR-1:0][7:0] config_bytes;
	int num_errors;
	int checks_done;
	int mflags;
	logic [7:0] got;
	logic [7:0] m;
	logic [7:0] vals[8];
	logic [7:0] exp_q[$];

	lef_event_flags #(.WAKE_PULSE_CYCLES(PULSE)) lef_event_flags_i (
		.mclk(mclk), .reset(reset), .bus_req(bus_req), .cond_raw(cond_raw),
		.line_low_raw(line_low_raw), .aux_low_raw(aux_low_raw), .rail_uv_raw(rail_uv_raw),
		.disturb_raw(disturb_raw), .rd_data(rd_data), .event_output_n(event_output_n),
		.driver_off(driver_off), .config_bytes(config_bytes)
	);
	lef_host_model lef_host_model_i (.mclk(mclk), .rd_data(rd_data), .bus_req(bus_req));

	// free-running clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// compare one value
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// falling-edge wait
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// read flags against the model, then reload the model
	task automatic rd_flags(input int keep);
		lef_host_model_i.rd(lef_pkg::ADDR_FLAGS, got);
		chk(got, mflags[7:0]);
		mflags = keep;
	endtask

	// verdict and end of run
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// watchdog against a hang
	initial
	begin
		#(8 * 20000);
		num_errors++;
		complete_run();
	end

	// main sequence
	initial
	begin
		num_errors = 0;
		checks_done = 0;
		reset = 1'b1;
		cond_raw = '0;
		line_low_raw = 1'b0;
		aux_low_raw = 1'b0;
		rail_uv_raw = 1'b0;
		disturb_raw = 1'b0;
		void'($urandom(32'h72d35cce));
		cyc(3);
		reset = 1'b0;
		mflags = 8'h80;
		cyc(2);
		chk(8'(event_output_n), 8'h00);
		chk(8'(driver_off), 8'h01);
		lef_host_model_i.rd(lef_pkg::ADDR_MASK, got);
		chk(got, lef_pkg::MASK_RESET);
		rd_flags(0);
		cyc(2);
		chk(8'(event_output_n), 8'h01);
		chk(8'(driver_off), 8'h00);
		$display("test powerup done");
		// each of the six condition inputs alone, then held across a read
		for (int i = 0; i < 6; i++)
		begin
			cond_raw = lef_pkg::lef_cond_t'(6'h01 << i);
			mflags = (i == 5) ? 8'h40 : (8'h01 << i);
			cyc(8);
			chk(8'(event_output_n), 8'h00);
			rd_flags(0);
			cyc(2);
			chk(8'(event_output_n), 8'h01);
			rd_flags(0);
			cond_raw = '0;
			cyc(8);
		end
		$display("test sources done");
		m = 8'($urandom);
		lef_host_model_i.wr(lef_pkg::ADDR_MASK, m);
		lef_host_model_i.rd(lef_pkg::ADDR_MASK, got);
		chk(got, m & 8'h5f);
		cond_raw = lef_pkg::lef_cond_t'(6'h1f);
		mflags = 8'h1f;
		cyc(8);
		chk(8'(event_output_n), 8'((m & 8'h1f) == 8'h1f));
		rd_flags(0);
		cond_raw = '0;
		$display("test mask done");
		lef_host_model_i.wr(lef_pkg::ADDR_MASK, 8'h40);
		cond_raw.wake = 1'b1;
		mflags = 8'h40;
		cyc(4);
		cond_raw.wake = 1'b0;
		cyc(4);
		chk(8'(event_output_n), 8'h00);
		cyc(PULSE + 4);
		chk(8'(event_output_n), 8'h01);
		rd_flags(0);
		$display("test wake pulse done");
		lef_host_model_i.wr(lef_pkg::ADDR_MASK, 8'h1f);
		rail_uv_raw = 1'b1;
		cyc(8);
		rail_uv_raw = 1'b0;
		mflags = 8'h80;
		cyc(8);
		chk(config_bytes[0], 8'h00);
		chk(8'(event_output_n), 8'h00);
		chk(8'(driver_off), 8'h01);
		rd_flags(0);
		$display("test rail done");
		disturb_raw = 1'b1;
		cyc(4);
		disturb_raw = 1'b0;
		mflags = 8'h80;
		cyc(8);
		lef_host_model_i.rd(lef_pkg::ADDR_INTEG, got);
		chk(got, 8'h80);
		chk(8'(driver_off), 8'h01);
		rd_flags(8'h80);
		rd_flags(8'h80);
		for (int i = 0; i < 8; i++)
			vals[i] = 8'($urandom);
		lef_host_model_i.rewrite(vals);
		lef_host_model_i.rd(lef_pkg::ADDR_INTEG, got);
		chk(got, 8'h00);
		for (int i = 0; i < 8; i++)
			chk(config_bytes[i], (i == 0) ? (vals[0] & 8'h5f) : vals[i]);
		rd_flags(0);
		rd_flags(0);
		cyc(2);
		chk(8'(event_output_n), 8'h01);
		chk(8'(driver_off), 8'h00);
		$display("test corruption done");
		line_low_raw = 1'b1;
		aux_low_raw = 1'b1;
		cond_raw.th_warn = 1'b1;
		cyc(8);
		lef_host_model_i.wr(lef_pkg::ADDR_PART_ID, 8'h00);
		lef_host_model_i.wr(lef_pkg::ADDR_SOFT_RST, 8'h80);
		mflags = 0;
		exp_q = '{8'h20, 8'h00, 8'h0c, 8'h5a, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02, 8'hc1};
		while (exp_q.size() > 1)
		begin
			lef_host_model_i.rd(exp_q.pop_front(), got);
			chk(got, exp_q.pop_front());
		end
		rd_flags(0);
		cond_raw = '0;
		line_low_raw = 1'b0;
		aux_low_raw = 1'b0;
		$display("test registers done");
		// second power-up in mid-run
		lef_host_model_i.wr(lef_pkg::ADDR_MASK, 8'h1f);
		reset = 1'b1;
		cyc(3);
		reset = 1'b0;
		mflags = 8'h80;
		cyc(2);
		chk(8'(event_output_n), 8'h00);
		chk(8'(driver_off), 8'h01);
		chk(config_bytes[lef_pkg::IDX_MASK], lef_pkg::MASK_RESET);
		rd_flags(0);
		$display("test second reset done");
		complete_run();
	end
endmodule
